// ### hdl/csu_pkg.sv
// constants, register map and field layout of the codec serial unit
package csu_pkg;
   // ----------------------------------------
   // register byte offsets (haddr[7:0])
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL1 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_CLKDIV = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_RXEN = 8'h10;
   localparam logic [7:0] OFS_TXEN = 8'h14;
   localparam logic [3:0] OFS_RXBUF_HI = 4'h2;
   localparam logic [3:0] OFS_TXBUF_HI = 4'h3;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int C1_EN = 15;
   localparam int C1_IDLE = 13;
   localparam int C1_LOOP = 11;
   localparam int C1_SCKD = 10;
   localparam int C1_CKE = 9;
   localparam int C1_FSD = 8;
   localparam int C1_UNDERFLOW_MODE = 7;
   localparam int C1_DOM = 6;
   localparam int C1_DATA_JUSTIFY = 5;
   localparam int C1_FSM = 0;
   localparam int C2_DEPTH = 10;
   localparam int C2_FLEN = 5;
   localparam int C2_WS = 0;
   localparam int ST_SLOT = 8;
   localparam int ST_ROV = 3;
   localparam int ST_RECEIVE_FULL = 2;
   localparam int ST_TRANSMIT_UNDERFLOW = 1;
   localparam int ST_TRANSMIT_EMPTY = 0;
   // ----------------------------------------
   // writable bit masks and reset values
   // ----------------------------------------
   localparam logic [15:0] CTRL1_MASK = 16'hAFE3;
   localparam logic [15:0] CTRL2_MASK = 16'h0DEF;
   localparam logic [15:0] CLKDIV_MASK = 16'h0FFF;
   localparam logic [15:0] RST_REG = 16'h0000;
   localparam logic [7:0] AC_SYNC_BITS = 8'h10;
   // ----------------------------------------
   // frame sync modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      CSU_FS_MULTI = 2'h0,
      CSU_FS_I2S = 2'h1,
      CSU_FS_AC16 = 2'h2,
      CSU_FS_AC20 = 2'h3
   } csu_fs_mode_t;
endpackage

// ### hdl/csu_codec_serial.sv
// codec serial unit: AHB-Lite registers, shadow buffer, shift engine, clock and frame sync
`timescale 1ns/100ps
module csu_codec_serial (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cpu_idle,
   input wire logic serial_bit_clock_in,
   output logic serial_bit_clock_out,
   output logic serial_bit_clock_oe,
   input wire logic frame_sync_pin_in,
   output logic frame_sync_pin_out,
   output logic frame_sync_pin_oe,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_oe
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] sck_sync;
      logic [2:0] fs_sync;
      logic [1:0] sdi_sync;
      logic [15:0] ctrl1;
      logic [15:0] ctrl2;
      logic [15:0] clkdiv;
      logic [15:0] rxen;
      logic [15:0] txen;
      logic [7:0][15:0] shadow;
      logic [7:0][15:0] cpu_buf;
      logic [15:0] last_tx;
      logic [15:0] sh;
      logic [11:0] div_cnt;
      logic sck_int;
      logic sck_prev;
      logic fs_prev;
      logic [3:0] slot;
      logic [3:0] bitc;
      logic [7:0] fbit;
      logic [1:0] ptr;
      logic [1:0] cur_ptr;
      logic cur_rx;
      logic cur_tx;
      logic sdo;
      logic sdo_oe;
      logic fs_out;
      logic receive_overflow;
      logic receive_full;
      logic transmit_underflow;
      logic transmit_empty;
      logic ph_valid;
      logic ph_write;
      logic [7:0] ph_addr;
   } csu_state_t;

   csu_state_t q;
   csu_state_t next_q;

   logic en, run, sck_lvl, drv, smp, last, sdi_eff, fs_long, blk_end;
   logic [3:0] ws, flen;
   logic [1:0] depth;
   logic [7:0] lead, fs_len;
   logic [15:0] rx_word;

   // ----------------------------------------
   // control decode
   // ----------------------------------------
   assign en = q.ctrl1[csu_pkg::C1_EN];
   assign run = en && !(q.ctrl1[csu_pkg::C1_IDLE] && cpu_idle);
   assign ws = q.ctrl2[csu_pkg::C2_WS +: 4];
   assign flen = q.ctrl2[csu_pkg::C2_FLEN +: 4];
   assign depth = q.ctrl2[csu_pkg::C2_DEPTH +: 2];
   // external clock is only ever looked at after the second stage
   assign sck_lvl = q.ctrl1[csu_pkg::C1_SCKD] ? q.sck_sync[1] : q.sck_int;
   assign drv = run && (q.ctrl1[csu_pkg::C1_CKE] ? (!sck_lvl && q.sck_prev) : (sck_lvl && !q.sck_prev));
   assign smp = run && (q.ctrl1[csu_pkg::C1_CKE] ? (sck_lvl && !q.sck_prev) : (!sck_lvl && q.sck_prev));
   assign last = (q.slot == flen) && (q.bitc == ws);
   assign sdi_eff = q.ctrl1[csu_pkg::C1_LOOP] ? q.sdo : q.sdi_sync[1];
   assign rx_word = q.sh << (4'hF - ws);
   assign blk_end = drv && (q.bitc == ws) && (q.cur_rx || q.cur_tx) && (q.cur_ptr == depth);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_q = q;
      lead = 8'h00;
      fs_len = 8'h00;
      fs_long = 1'b0;
      next_q.sck_sync = {q.sck_sync[1:0], serial_bit_clock_in};
      next_q.fs_sync = {q.fs_sync[1:0], frame_sync_pin_in};
      next_q.sdi_sync = {q.sdi_sync[0], serial_data_in};
      next_q.sck_prev = sck_lvl;
      // bus: address phase capture, data phase action
      if (hready) begin
         next_q.ph_valid = hsel && htrans[1];
         next_q.ph_write = hwrite;
         next_q.ph_addr = haddr[7:0];
      end
      if (q.ph_valid && q.ph_write) begin
         case (q.ph_addr)
            csu_pkg::OFS_CTRL1: next_q.ctrl1 = hwdata[15:0] & csu_pkg::CTRL1_MASK;
            csu_pkg::OFS_CTRL2: next_q.ctrl2 = hwdata[15:0] & csu_pkg::CTRL2_MASK;
            csu_pkg::OFS_CLKDIV: next_q.clkdiv = hwdata[15:0] & csu_pkg::CLKDIV_MASK;
            csu_pkg::OFS_RXEN: next_q.rxen = hwdata[15:0];
            csu_pkg::OFS_TXEN: next_q.txen = hwdata[15:0];
            default: begin
               if (q.ph_addr[7:4] == csu_pkg::OFS_TXBUF_HI) begin
                  next_q.cpu_buf[{1'b1, q.ph_addr[3:2]}] = hwdata[15:0];
                  next_q.last_tx = hwdata[15:0];
                  next_q.transmit_empty = 1'b0;
               end
            end
         endcase
      end
      if (q.ph_valid && !q.ph_write && q.ph_addr[7:4] == csu_pkg::OFS_RXBUF_HI) begin
         next_q.receive_full = 1'b0;
      end
      // bit clock generator
      if (run && !q.ctrl1[csu_pkg::C1_SCKD]) begin
         if (q.div_cnt >= q.clkdiv[11:0]) begin
            next_q.div_cnt = 12'h000;
            next_q.sck_int = !q.sck_int;
         end else begin
            next_q.div_cnt = q.div_cnt + 12'h001;
         end
      end
      // sample edge: shift in, watch external frame sync
      if (smp) begin
         next_q.sh = {q.sh[14:0], sdi_eff};
         next_q.fs_prev = q.fs_sync[1];
         if (q.ctrl1[csu_pkg::C1_FSD] && q.fs_sync[1] && !q.fs_prev) begin
            if (q.ctrl1[csu_pkg::C1_DATA_JUSTIFY]) begin
               next_q.slot = 4'h0;
               next_q.bitc = 4'h0;
            end else begin
               next_q.slot = flen;
               next_q.bitc = ws;
            end
         end
      end
      // drive edge: word end, advance, word start, output bit
      if (drv) begin
         if (q.bitc == ws) begin
            if (q.cur_rx) begin
               next_q.shadow[{1'b0, q.cur_ptr}] = rx_word;
            end
            if (blk_end) begin
               // block hand-over gives software a whole block time to refill
               next_q.receive_overflow = q.receive_overflow || next_q.receive_full;
               next_q.receive_full = 1'b1;
               next_q.transmit_underflow = q.transmit_underflow || next_q.transmit_empty;
               for (int i = 0; i < 4; i++) begin
                  next_q.cpu_buf[i] = next_q.shadow[i];
                  if (next_q.transmit_empty) begin
                     next_q.shadow[4 + i] = q.ctrl1[csu_pkg::C1_UNDERFLOW_MODE] ? q.last_tx : 16'h0000;
                  end else begin
                     next_q.shadow[4 + i] = next_q.cpu_buf[4 + i];
                  end
               end
               next_q.transmit_empty = 1'b1;
            end
            next_q.bitc = 4'h0;
            next_q.slot = (q.slot == flen) ? 4'h0 : q.slot + 4'h1;
            next_q.cur_rx = q.rxen[next_q.slot];
            next_q.cur_tx = q.txen[next_q.slot];
            if (next_q.cur_rx || next_q.cur_tx) begin
               next_q.cur_ptr = q.ptr;
               next_q.ptr = (q.ptr == depth) ? 2'h0 : q.ptr + 2'h1;
            end
            next_q.sh = next_q.cur_tx ? next_q.shadow[{1'b1, q.ptr}] : 16'h0000;
            next_q.sdo = next_q.cur_tx && next_q.sh[15];
            next_q.sdo_oe = next_q.cur_tx || !q.ctrl1[csu_pkg::C1_DOM];
         end else begin
            next_q.bitc = q.bitc + 4'h1;
            next_q.sdo = q.cur_tx && q.sh[15];
         end
         next_q.fbit = last ? 8'h00 : q.fbit + 8'h01;
         // frame sync shaping: lead is the bit index counted from the pulse
         if (q.ctrl1[csu_pkg::C1_DATA_JUSTIFY]) begin
            lead = next_q.fbit;
         end else begin
            lead = (next_q.slot == flen && next_q.bitc == ws) ? 8'h00 : next_q.fbit + 8'h01;
         end
         case (csu_pkg::csu_fs_mode_t'(q.ctrl1[csu_pkg::C1_FSM +: 2]))
            csu_pkg::CSU_FS_MULTI: fs_len = 8'h01;
            csu_pkg::CSU_FS_I2S: fs_len = {4'h0, ws} + 8'h01;
            default: fs_long = 1'b1;
         endcase
         if (fs_long) begin
            fs_len = csu_pkg::AC_SYNC_BITS;
         end
         next_q.fs_out = lead < fs_len;
      end
      if (!en) begin
         next_q.slot = flen;
         next_q.bitc = ws;
         next_q.fbit = 8'h00;
         next_q.ptr = 2'h0;
         next_q.cur_ptr = 2'h0;
         next_q.cur_rx = 1'b0;
         next_q.cur_tx = 1'b0;
         next_q.sdo = 1'b0;
         next_q.sdo_oe = 1'b0;
         next_q.fs_out = 1'b0;
         next_q.div_cnt = 12'h000;
         next_q.sck_int = 1'b0;
         next_q.receive_overflow = 1'b0;
         next_q.transmit_underflow = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign serial_bit_clock_out = q.sck_int;
   assign serial_bit_clock_oe = en && !q.ctrl1[csu_pkg::C1_SCKD];
   assign frame_sync_pin_out = q.fs_out;
   assign frame_sync_pin_oe = en && !q.ctrl1[csu_pkg::C1_FSD];
   assign serial_data_out = q.sdo;
   assign serial_data_out_oe = q.sdo_oe;

   always_comb begin
      hrdata = 32'h0000_0000;
      if (q.ph_valid && !q.ph_write) begin
         case (q.ph_addr)
            csu_pkg::OFS_CTRL1: hrdata[15:0] = q.ctrl1;
            csu_pkg::OFS_CTRL2: hrdata[15:0] = q.ctrl2;
            csu_pkg::OFS_CLKDIV: hrdata[15:0] = q.clkdiv;
            csu_pkg::OFS_STAT: hrdata[15:0] = {4'h0, q.slot, 4'h0, q.receive_overflow, q.receive_full, q.transmit_underflow, q.transmit_empty};
            csu_pkg::OFS_RXEN: hrdata[15:0] = q.rxen;
            csu_pkg::OFS_TXEN: hrdata[15:0] = q.txen;
            default: begin
               if (q.ph_addr[7:5] == 3'h1) begin
                  hrdata[15:0] = q.cpu_buf[{q.ph_addr[4], q.ph_addr[3:2]}];
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_word_end;
      drv && q.bitc == ws && !last;
   endsequence
   sequence s_frame_end;
      drv && last;
   endsequence

   property p_disable_quiet;
      @(posedge clk_sys) disable iff (!resetn)
      !en ##1 !en |-> !serial_data_out_oe && !serial_bit_clock_oe && !frame_sync_pin_oe && !q.fs_out;
   endproperty
   a_disable_quiet: assert property (p_disable_quiet) else $error("outputs active while disabled");

   property p_idle_halt;
      @(posedge clk_sys) disable iff (!resetn)
      en && q.ctrl1[csu_pkg::C1_IDLE] && cpu_idle |=> $stable(q.slot) && $stable(q.bitc);
   endproperty
   a_idle_halt: assert property (p_idle_halt) else $error("unit advanced in idle stop");

   property p_loopback;
      @(posedge clk_sys) disable iff (!resetn)
      smp && q.ctrl1[csu_pkg::C1_LOOP] |=> q.sh[0] == $past(q.sdo);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback bit not captured");

   property p_idle_slot_low;
      @(posedge clk_sys) disable iff (!resetn)
      en && !q.cur_tx ##1 en && !q.cur_tx && $past(drv) |-> !q.sdo && (q.sdo_oe == !q.ctrl1[csu_pkg::C1_DOM]);
   endproperty
   a_idle_slot_low: assert property (p_idle_slot_low) else $error("disabled slot output wrong");

   property p_word_wrap;
      @(posedge clk_sys) disable iff (!resetn)
      s_word_end |=> q.bitc == 4'h0 && q.slot == $past(q.slot) + 4'h1;
   endproperty
   a_word_wrap: assert property (p_word_wrap) else $error("word length wrong");

   property p_frame_wrap;
      @(posedge clk_sys) disable iff (!resetn)
      s_frame_end |=> q.slot == 4'h0 && q.bitc == 4'h0 && q.fbit == 8'h00;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not wrap");

   property p_overflow;
      @(posedge clk_sys) disable iff (!resetn)
      blk_end && q.receive_full && !(q.ph_valid && !q.ph_write && q.ph_addr[7:4] == csu_pkg::OFS_RXBUF_HI) |=> q.receive_overflow && q.receive_full;
   endproperty
   a_overflow: assert property (p_overflow) else $error("receive overflow missed");

   property p_underflow_zero;
      @(posedge clk_sys) disable iff (!resetn)
      blk_end && q.transmit_empty && !q.ctrl1[csu_pkg::C1_UNDERFLOW_MODE] && !(q.ph_valid && q.ph_write) |=> q.transmit_underflow && q.shadow[4] == 16'h0000;
   endproperty
   a_underflow_zero: assert property (p_underflow_zero) else $error("underflow did not send zeros");

   property p_ptr_wrap;
      @(posedge clk_sys) disable iff (!resetn)
      drv && q.bitc == ws && en && q.ptr == depth && (q.rxen[next_q.slot] || q.txen[next_q.slot]) |=> q.ptr == 2'h0;
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("word counter did not wrap at depth");

   property p_div_period;
      // a stop or disable in mid-period abandons the attempt
      @(posedge clk_sys) disable iff (!resetn || !run)
      !q.ctrl1[csu_pkg::C1_SCKD] && q.clkdiv == 16'h0002 && $changed(q.sck_int)
         |=> $stable(q.sck_int) ##1 $stable(q.sck_int) ##1 $changed(q.sck_int);
   endproperty
   a_div_period: assert property (p_div_period) else $error("bit clock period wrong");
endmodule // csu_codec_serial

// ### verif/csu_codec_model.sv
// behavioural external codec: bursts of bit clock, frame sync and serial data
`timescale 1ns/100ps
module csu_codec_model (
   input wire logic go,
   input wire logic [15:0] tx_word,
   input wire logic sdo_line,
   output logic sck,
   output logic fs,
   output logic sdi,
   output logic [15:0] seen,
   output logic busy
);
   // ----------------------------------------
   // frame burst
   // ----------------------------------------
   logic [15:0] sh;
   int k;
   initial begin
      sck = 1'b0;
      fs = 1'b0;
      sdi = 1'b0;
      busy = 1'b0;
      seen = 16'h0000;
      sh = 16'h0000;
      forever begin
         @(posedge go);
         busy = 1'b1;
         #37;
         // clock runs only inside the burst, stands low between bursts
         for (k = 0; k < 129; k++) begin
            // frame sync one bit ahead of slot 0, changes on falling edge
            fs = (k % 16 == 0);
            sdi = (k == 0) ? ~sdi : tx_word[15 - ((k - 1) % 16)];
            #100 sck = 1'b1;
            // device output sampled on rising edge
            if (k > 0) sh = {sh[14:0], sdo_line};
            if (k > 0 && (k - 1) % 16 == 15) seen = sh;
            #100 sck = 1'b0;
         end
         fs = 1'b0;
         busy = 1'b0;
      end
   end
   // released data line never holds its last value
   always #100 if (!busy) sdi = ~sdi;
endmodule // csu_codec_model

// ### verif/csu_codec_serial_test.sv
// self-checking bench of the codec serial unit
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module csu_codec_serial_test;
   logic clk_sys, resetn, hsel, hwrite, hready, hreadyout, hresp, cpu_idle, go, busy, tgl, rd_ph;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic sck_out, sck_oe, fs_out, fs_oe, sdo, sdo_oe, m_sck, m_fs, m_sdi;
   logic [15:0] m_word, seen;
   logic [31:0] qe[$], qm[$];
   logic [31:0] exp_w, msk_w;
   int n_mismatch = 0, checks = 0, cyc = 0, i;
   localparam logic [7:0] RXB = {csu_pkg::OFS_RXBUF_HI, 4'h0};
   localparam logic [7:0] TXB = {csu_pkg::OFS_TXBUF_HI, 4'h0};
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) tgl <= ~tgl;
   assign hready = hreadyout;
   csu_codec_serial csu_codec_serial_inst (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_idle(cpu_idle),
      .serial_bit_clock_in(sck_oe ? sck_out : m_sck), .serial_bit_clock_out(sck_out),
      .serial_bit_clock_oe(sck_oe), .frame_sync_pin_in(fs_oe ? fs_out : m_fs),
      .frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe), .serial_data_in(m_sdi),
      .serial_data_out(sdo), .serial_data_out_oe(sdo_oe));
   csu_codec_model csu_codec_model_inst (.go(go), .tx_word(m_word), .sdo_line(sdo_oe ? sdo : tgl),
      .sck(m_sck), .fs(m_fs), .sdi(m_sdi), .seen(seen), .busy(busy));
   // ----------------------------------------
   // verdict, timeout, lfsr
   // ----------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // ----------------------------------------
   // ahb-lite master and read monitor
   // ----------------------------------------
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (n >= 100) begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h00000000;
      if (!w) begin
         qe.push_back(d);
         qm.push_back(m);
      end
      rd_ph <= ~w;
      wait_rdy();
      rd_ph <= 1'b0;
   endtask
   // read data stands in the data phase cycle only
   always @(posedge clk_sys) if (rd_ph === 1'b1) begin
      // pop once: the macro names its arguments more than once
      exp_w = qe.pop_front();
      msk_w = qm.pop_front();
      `CHECK("hrdata", exp_w, hrdata & msk_w)
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; cpu_idle = 1'b0; go = 1'b0; m_word = 16'h0; rd_ph = 1'b0; tgl = 1'b0;
      v = 32'hAF31A6D6;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      hsel <= 1'b1;
      for (i = 0; i < 6; i++) bus(8'(i * 4), 1'b0, 32'h0, 32'hFFFFFFFF);
      `CHECK("pins_off", 3'h0, {sck_oe, fs_oe, sdo_oe})
      bus(csu_pkg::OFS_STAT, 1'b1, 32'hFFFF, 0);
      bus(csu_pkg::OFS_STAT, 1'b0, 32'h0, 32'hFFFFFFFF);
      bus(8'h40, 1'b1, 32'hFFFF, 0);
      bus(8'h40, 1'b0, 32'h0, 32'hFFFFFFFF);
      bus(csu_pkg::OFS_CTRL2, 1'b1, 32'hFFFF, 0);
      bus(csu_pkg::OFS_CTRL2, 1'b0, {16'h0, csu_pkg::CTRL2_MASK}, 32'hFFFFFFFF);
      bus(csu_pkg::OFS_CLKDIV, 1'b1, 32'hFFFF, 0);
      bus(csu_pkg::OFS_CLKDIV, 1'b0, {16'h0, csu_pkg::CLKDIV_MASK}, 32'hFFFFFFFF);
      v = lfsr(v);
      bus(csu_pkg::OFS_RXEN, 1'b1, v, 0);
      bus(csu_pkg::OFS_RXEN, 1'b0, {16'h0, v[15:0]}, 32'hFFFFFFFF);
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'hFFFF, 0);
      bus(csu_pkg::OFS_CTRL1, 1'b0, {16'h0, csu_pkg::CTRL1_MASK}, 32'hFFFFFFFF);
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h0, 0);
      $display("test registers done");
      // loopback, 8-bit words, one-word frames, underflow repeats last word
      bus(csu_pkg::OFS_CTRL2, 1'b1, 32'h0007, 0);
      bus(csu_pkg::OFS_CLKDIV, 1'b1, 32'h0002, 0);
      bus(csu_pkg::OFS_RXEN, 1'b1, 32'h0001, 0);
      bus(csu_pkg::OFS_TXEN, 1'b1, 32'h0001, 0);
      v = lfsr(v);
      bus(TXB, 1'b1, v, 0);
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h8A80, 0);
      repeat (3000) @(posedge clk_sys);
      `CHECK("clk_dirs", 2'h3, {sck_oe, fs_oe})
      bus(csu_pkg::OFS_STAT, 1'b0, 32'h0006, 32'h0006);
      bus(RXB, 1'b0, {16'h0, v[15:8], 8'h00}, 32'hFFFFFFFF);
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h8A00, 0);
      repeat (3000) @(posedge clk_sys);
      bus(RXB, 1'b0, 32'h0, 32'hFFFFFFFF);
      $display("test loopback done");
      // idle stop freezes the slot counter; disabled slots tri-state or drive low
      bus(csu_pkg::OFS_CTRL2, 1'b1, 32'h0C6F, 0);
      bus(csu_pkg::OFS_TXEN, 1'b1, 32'h0, 0);
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h0, 0);
      cpu_idle <= 1'b1;
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'hA040, 0);
      repeat (200) @(posedge clk_sys);
      bus(csu_pkg::OFS_STAT, 1'b0, 32'h0300, 32'h0F00);
      `CHECK("sdo_oe_tri", 1'b0, sdo_oe)
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h8000, 0);
      repeat (200) @(posedge clk_sys);
      `CHECK("sdo_low", 2'h2, {sdo_oe, sdo})
      $display("test idle done");
      // external clock and frame sync from the codec
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h0, 0);
      cpu_idle <= 1'b0;
      bus(csu_pkg::OFS_CTRL2, 1'b1, 32'h000F, 0);
      bus(csu_pkg::OFS_TXEN, 1'b1, 32'h0001, 0);
      v = lfsr(v);
      m_word <= v[31:16];
      bus(TXB, 1'b1, v, 0);
      bus(csu_pkg::OFS_CTRL1, 1'b1, 32'h8780, 0);
      `CHECK("ext_dirs", 2'h0, {sck_oe, fs_oe})
      go <= 1'b1;
      repeat (3000) begin
         @(posedge clk_sys);
         go <= 1'b0;
      end
      `CHECK("codec_seen", v[15:0], seen)
      bus(RXB, 1'b0, {16'h0, v[31:16]}, 32'hFFFFFFFF);
      $display("test external done");
      print_verdict();
   end
endmodule // csu_codec_serial_test
